// File: design/mop_top.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "mop_params.svh"
module mop_top
  import mop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic emergencyStopIn,
  input wire logic overloadIn,
  input wire logic [5:0] patternIn,
  input wire logic [5:0] pwmPhaseIn,
  input wire logic polarityHigh,
  input wire logic timerSync,
  input wire logic pwmSync,
  output logic [5:0] motorOut,
  output logic [5:0] motorOutEn_n,
  output logic emergencyIrq,
  output logic overloadIrq,
  output logic counterHalt
);
  // ************************************************************
  // whole block state in one record
  // ************************************************************
  typedef struct packed {
    logic emgEnable; // emergency protection on
    logic emgActive; // emergency state in force
    logic emgPrev; // last synced emergency level
    logic [3:0] sampleCount; // overload sample count
    logic ovlEnable; // overload protection on
    logic ovlActive; // overload state in force
    logic rtnTmr; // return on timer sync
    logic rtnPwm; // return on pwm sync
    mop_cut_t cutSel; // phases cut in overload
    logic haltSel; // halt counter in overload
    mop_key_t keyState; // unlock progress
    logic upperWin; // upper majority at cut
    logic lowerWin; // lower majority at cut
    logic [5:0] outVal;
    logic [5:0] outEn_n;
    logic emgIrq;
    logic ovlIrq;
    logic halt;
    logic ack;
    logic [7:0] rdData;
  } mop_state_t;

  mop_state_t st_reg;
  mop_state_t st_next;
  logic [1:0] syncIn; // bit 1 emergency, bit 0 overload
  logic ovlDetect;
  logic emgFall;
  logic busReq;
  logic busWr;
  logic rteCmd;
  logic ovlRtnCmd;
  logic [5:0] onBits;
  logic [5:0] cutMask;
  logic [5:0] inactive;
  logic [7:0] wrByte;

  // majority of three phases
  function automatic logic two_of_three(input logic [2:0] v);
    two_of_three = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // ************************************************************
  // input conditioning
  // ************************************************************
  // both fault pins cross into the clock domain first
  mop_input_sync u_sync (
    .clk(clk),
    .reset(reset),
    .asyncIn({emergencyStopIn, overloadIn}),
    .syncOut(syncIn)
  );

  // overload low counting on the synced pin
  mop_overload_sampler u_samp (
    .clk(clk),
    .reset(reset),
    .sampleIn(syncIn[0]),
    .countSel(st_reg.sampleCount),
    .detected(ovlDetect)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    wrByte = wb_dat_i[7:0];
    busReq = wb_cyc_i && wb_stb_i && !st_reg.ack;
    busWr = busReq && wb_we_i && wb_sel_i[0];
    emgFall = st_reg.emgPrev && !syncIn[1];
    rteCmd = 1'b0;
    ovlRtnCmd = 1'b0;
    onBits = polarityHigh ? patternIn : ~patternIn;
    inactive = polarityHigh ? 6'h00 : `MOP_ALL_PHASES;
    cutMask = 6'h00;
    st_next.emgPrev = syncIn[1];
    st_next.emgIrq = 1'b0;
    st_next.ovlIrq = 1'b0;
    // one ack per request, dropped the next cycle
    st_next.ack = busReq;

    // register writes, single-cycle slave
    if (busWr) begin
      if (wb_adr_i == `MOP_ADR_EMG_CTRL) begin
        st_next.sampleCount = wrByte[7:4];
        rteCmd = wrByte[`MOP_BIT_RTE];
        // clearing the enable only works once unlocked
        st_next.emgEnable = wrByte[`MOP_BIT_EN] ||
          (st_reg.emgEnable && st_reg.keyState != MOP_KEY_OPEN);
        st_next.keyState = MOP_KEY_IDLE;
      end else if (wb_adr_i == `MOP_ADR_OVL_CTRL) begin
        ovlRtnCmd = wrByte[`MOP_BIT_RTCMD];
        st_next.rtnPwm = wrByte[`MOP_BIT_OVERLOAD_RETURN_ON_PWM_SYNC];
        st_next.rtnTmr = wrByte[`MOP_BIT_RTTMR];
        st_next.cutSel = mop_cut_t'(wrByte[3:2]);
        st_next.haltSel = wrByte[`MOP_BIT_HALT];
        st_next.ovlEnable = wrByte[`MOP_BIT_EN];
      end else if (wb_adr_i == `MOP_ADR_KEY) begin
        // any wrong byte restarts the sequence
        if (wrByte == `MOP_KEY_FIRST) begin
          st_next.keyState = MOP_KEY_HALF;
        end else if (wrByte == `MOP_KEY_SECOND && st_reg.keyState == MOP_KEY_HALF) begin
          st_next.keyState = MOP_KEY_OPEN;
        end else begin
          st_next.keyState = MOP_KEY_IDLE;
        end
      end
    end

    // register reads; key and command bits read as zero
    st_next.rdData = 8'h00;
    if (busReq && !wb_we_i) begin
      if (wb_adr_i == `MOP_ADR_EMG_CTRL) begin
        st_next.rdData = {st_reg.sampleCount, 1'b0, st_reg.emgActive, 1'b0,
          st_reg.emgEnable};
      end else if (wb_adr_i == `MOP_ADR_OVL_CTRL) begin
        st_next.rdData = {1'b0, st_reg.rtnPwm, st_reg.rtnTmr, st_reg.ovlActive,
          st_reg.cutSel, st_reg.haltSel, st_reg.ovlEnable};
      end
    end

    // emergency return only with the pin back high
    if (st_reg.emgActive && rteCmd && syncIn[1]) begin
      st_next.emgActive = 1'b0;
    end
    // a trip in the same cycle beats the return
    if (st_reg.emgEnable && emgFall) begin
      st_next.emgActive = 1'b1;
      st_next.emgIrq = 1'b1;
    end

    // overload return: command first, then the syncs
    if (st_reg.ovlActive && syncIn[0] && !ovlDetect) begin
      if (ovlRtnCmd) begin
        st_next.ovlActive = 1'b0;
      end else if ((st_reg.rtnTmr && timerSync) || (st_reg.rtnPwm && pwmSync)) begin
        st_next.ovlActive = 1'b0;
      end
    end
    if (!st_next.ovlEnable) begin
      st_next.ovlActive = 1'b0;
    end else if (ovlDetect && !st_reg.ovlActive) begin
      st_next.ovlActive = 1'b1;
      st_next.ovlIrq = 1'b1;
      // freeze the on-state seen just before the cut
      st_next.upperWin = two_of_three(onBits[2:0]);
      st_next.lowerWin = two_of_three(onBits[5:3]);
    end

    st_next.halt = st_next.ovlActive && st_next.haltSel;

    // ************************************************************
    // output stage, registered from the next state
    // ************************************************************
    st_next.outEn_n = 6'h00;
    st_next.outVal = patternIn;
    if (st_next.emgActive) begin
      st_next.outEn_n = `MOP_ALL_PHASES;
      st_next.outVal = inactive;
    end else if (st_next.ovlActive) begin
      case (st_next.cutSel)
        MOP_CUT_NONE: begin
          cutMask = 6'h00;
        end
        MOP_CUT_ALL: begin
          cutMask = `MOP_ALL_PHASES;
        end
        MOP_CUT_PWM: begin
          cutMask = pwmPhaseIn;
        end
        default: begin
          cutMask = `MOP_ALL_PHASES;
        end
      endcase
      st_next.outVal = (patternIn & ~cutMask) | (inactive & cutMask);
      if (st_next.cutSel == MOP_CUT_UL) begin
        // neither side in majority leaves every phase off
        if (st_next.upperWin) begin
          st_next.outVal = {inactive[5:3], ~inactive[2:0]};
        end else if (st_next.lowerWin) begin
          st_next.outVal = {~inactive[5:3], inactive[2:0]};
        end
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.emgEnable <= 1'b1;
      st_reg.emgPrev <= 1'b1;
      st_reg.cutSel <= MOP_CUT_NONE;
      st_reg.keyState <= MOP_KEY_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = {24'h000000, st_reg.rdData};
  assign wb_ack_o = st_reg.ack;
  assign motorOut = st_reg.outVal;
  assign motorOutEn_n = st_reg.outEn_n;
  assign emergencyIrq = st_reg.emgIrq;
  assign overloadIrq = st_reg.ovlIrq;
  assign counterHalt = st_reg.halt;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence sEmgTrip;
    st_reg.emgEnable && emgFall;
  endsequence
  sequence sEmgOut;
    (motorOutEn_n == `MOP_ALL_PHASES) && emergencyIrq;
  endsequence
  sequence sEmgHold;
    (motorOutEn_n == `MOP_ALL_PHASES) && !emergencyIrq;
  endsequence

  a_emg_trip_hiz: assert property (sEmgTrip |=> sEmgOut ##1 sEmgHold)
    else $error("emergency trip did not float outputs");
  a_emg_status_read: assert property (busReq && !wb_we_i && wb_adr_i == `MOP_ADR_EMG_CTRL
    |=> wb_ack_o && wb_dat_o[`MOP_BIT_EMERGENCY_ACTIVE_FLAG] == $past(st_reg.emgActive))
    else $error("emergency status read wrong");
  a_emg_low_hold: assert property (st_reg.emgActive && !syncIn[1] |=> st_reg.emgActive)
    else $error("emergency left while input low");
  a_emg_lock_keep: assert property (busWr && wb_adr_i == `MOP_ADR_EMG_CTRL
    && !wrByte[`MOP_BIT_EN] && st_reg.keyState != MOP_KEY_OPEN && st_reg.emgEnable
    |=> st_reg.emgEnable)
    else $error("emergency disabled without key");
  a_emg_irq_off: assert property (emergencyIrq |-> $past(st_reg.emgEnable))
    else $error("emergency irq while disabled");
  a_emg_reset_on: assert property ($fell(reset) |-> st_reg.emgEnable)
    else $error("emergency not enabled after reset");
  a_ovl_irq_off: assert property (overloadIrq |-> $past(st_reg.ovlEnable)
    && st_reg.ovlActive)
    else $error("overload irq while disabled");
  a_ovl_cmd_return: assert property (st_reg.ovlActive && ovlRtnCmd && syncIn[0]
    && !ovlDetect && st_next.ovlEnable |=> !st_reg.ovlActive ##1 !counterHalt)
    else $error("overload return command ignored");
  a_ovl_halt_run: assert property (st_reg.ovlActive && st_reg.haltSel |-> counterHalt)
    else $error("counter not halted in overload");
  a_ovl_cut_all: assert property (st_next.ovlActive && !st_next.emgActive
    && st_next.cutSel == MOP_CUT_ALL
    |=> motorOut == (($past(polarityHigh)) ? 6'h00 : `MOP_ALL_PHASES))
    else $error("cut phases not inactive");
endmodule

// File: design/mop_params.svh
// Summary of operation
// - enabled emergency fall: outputs hi-z, irq
// - read-only emergency active status bit
// - emergency return ignored while input low
// - key 5AH then A5H unlocks emergency disable
// - no emergency irq while disabled
// - emergency protection enabled after reset
// - overload acts only when enabled, input low
// - sample every 200 ns, count 1-15
// - return by timer, pwm sync, command
// - software overload return has top priority
// - outputs resume previous pattern after return
// - overload active status at bit 4
// - cut-off select field at bits 3:2
// - upper/lower cut-off follows majority before cut
// - cut phases drive their inactive level
// - no overload irq while disabled
// - counter halt during overload when selected
// - cut-off codes 00 none 01 all 10 pwm 11 ul
`ifndef MOP_PARAMS_SVH
`define MOP_PARAMS_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define MOP_IDX_EMG_CTRL 16'h1FB0
`define MOP_IDX_OVL_CTRL 16'h1FB1
`define MOP_IDX_KEY 16'h1FBF
`define MOP_ADR_EMG_CTRL 16'h7EC0
`define MOP_ADR_OVL_CTRL 16'h7EC4
`define MOP_ADR_KEY 16'h7EFC
// ************************************************************
// field positions and values
// ************************************************************
`define MOP_BIT_EN 0
`define MOP_BIT_RTE 1
`define MOP_BIT_EMERGENCY_ACTIVE_FLAG 2
`define MOP_BIT_HALT 1
`define MOP_BIT_OVLST 4
`define MOP_BIT_RTTMR 5
`define MOP_BIT_OVERLOAD_RETURN_ON_PWM_SYNC 6
`define MOP_BIT_RTCMD 7
`define MOP_KEY_FIRST 8'h5A
`define MOP_KEY_SECOND 8'hA5
`define MOP_EMG_RESET 8'h01
`define MOP_OVL_RESET 8'h00
`define MOP_ALL_PHASES 6'h3F
// ************************************************************
// timing
// ************************************************************
`define MOP_CLK_NS 10
`define MOP_SAMPLE_NS 200
`define MOP_SAMPLE_CYC (`MOP_SAMPLE_NS / `MOP_CLK_NS)
`endif

// File: design/mop_pkg.sv
package mop_pkg;
  // cut-off selection codes
  typedef enum logic [1:0] {
    MOP_CUT_NONE = 2'b00,
    MOP_CUT_ALL = 2'b01,
    MOP_CUT_PWM = 2'b10,
    MOP_CUT_UL = 2'b11
  } mop_cut_t;
  // unlock key progress
  typedef enum logic [1:0] {
    MOP_KEY_IDLE = 2'b00,
    MOP_KEY_HALF = 2'b01,
    MOP_KEY_OPEN = 2'b10
  } mop_key_t;
endpackage

// File: design/mop_input_sync.sv
`timescale 1ns/10ps
module mop_input_sync
  import mop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] asyncIn,
  output logic [1:0] syncOut
);
  // two-stage synchroniser state
  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } mop_sync_t;
  mop_sync_t st_reg;
  mop_sync_t st_next;

  // ************************************************************
  // next state: first stage feeds only the second
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = asyncIn;
    st_next.stage2 = st_reg.stage1;
  end

  // idle level of both inputs is high
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{stage1: 2'h3, stage2: 2'h3};
    end else begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.stage2;
endmodule

// File: design/mop_overload_sampler.sv
`timescale 1ns/10ps
`include "mop_params.svh"
module mop_overload_sampler
  import mop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sampleIn,
  input wire logic [3:0] countSel,
  output logic detected
);
  // divider and consecutive-low counter
  typedef struct packed {
    logic [4:0] tick;
    logic [3:0] lowCnt;
    logic det;
  } mop_samp_t;
  mop_samp_t st_reg;
  mop_samp_t st_next;
  logic [3:0] target;

  // ************************************************************
  // sampling every 200 ns; zero count acts as one
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    target = (countSel == 4'h0) ? 4'h1 : countSel;
    if (st_reg.tick == 5'(`MOP_SAMPLE_CYC - 1)) begin
      st_next.tick = 5'h00;
      if (!sampleIn) begin
        // saturate so a long fault never wraps back to zero
        if (st_reg.lowCnt != 4'hF) begin
          st_next.lowCnt = st_reg.lowCnt + 4'h1;
        end
        if (st_reg.lowCnt + 4'h1 >= target) begin
          st_next.det = 1'b1;
        end
      end else begin
        st_next.lowCnt = 4'h0;
        st_next.det = 1'b0;
      end
    end else begin
      st_next.tick = st_reg.tick + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{tick: 5'h00, lowCnt: 4'h0, det: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign detected = st_reg.det;
endmodule

// File: test/mop_power_stage.sv
`timescale 1ns/10ps
// ************************************************************
// fault sense side of the inverter power stage
// ************************************************************
module mop_power_stage (
  input wire logic clk,
  input wire logic emgFault,
  input wire logic ovlFault,
  output logic emergencyStopIn,
  output logic overloadIn
);
  // the lines are driven from a flop, so a released fault reads high one clock later;
  // one driver per line, the synchronisers are held in reset until it settles
  always @(posedge clk) begin
    emergencyStopIn <= ~emgFault;
    overloadIn <= ~ovlFault;
  end
endmodule

// File: test/motor_output_protection_tb.sv
`timescale 1ns/10ps
`include "mop_params.svh"
module motor_output_protection_tb
  import mop_pkg::*;
;
  // ************************************************************
  // stimulus and observation signals
  // ************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [15:0] wbAdr = 16'h0000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h00000000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic emgFault = 1'b0;
  logic ovlFault = 1'b0;
  logic emergencyStopIn;
  logic overloadIn;
  logic [5:0] pattern = 6'h00;
  logic [5:0] pwmPhase = 6'h00;
  logic timerSync = 1'b0;
  logic pwmSync = 1'b0;
  logic [5:0] motorOut;
  logic [5:0] motorOutEn_n;
  logic emergencyIrq;
  logic overloadIrq;
  logic counterHalt;
  logic [31:0] rd;
  logic [7:0] ctrl;
  logic [7:0] rets [4] = '{8'h00, 8'h20, 8'h40, 8'h60};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  int cnt;
  int eff;
  // longest path is four overload trips of up to 15 samples of 20 cycles
  localparam int LIMIT = 20000;
  always #5 clk = ~clk;
  mop_top uut (.clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .emergencyStopIn(emergencyStopIn),
    .overloadIn(overloadIn), .patternIn(pattern), .pwmPhaseIn(pwmPhase),
    .polarityHigh(1'b1), .timerSync(timerSync), .pwmSync(pwmSync),
    .motorOut(motorOut), .motorOutEn_n(motorOutEn_n), .emergencyIrq(emergencyIrq),
    .overloadIrq(overloadIrq), .counterHalt(counterHalt));
  mop_power_stage stage (.clk(clk), .emgFault(emgFault), .ovlFault(ovlFault),
    .emergencyStopIn(emergencyStopIn), .overloadIn(overloadIn));
  // ************************************************************
  // helpers
  // ************************************************************
  // hang guard: a stuck wait ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatI <= {24'h000000, d};
    // only the bench's hang guard ends a wait for ack
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wait_irq(input logic ovl, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (((ovl ? overloadIrq : emergencyIrq) !== 1'b1) && c < lim);
  endtask
  task automatic pulse(input logic t, input logic p);
    @(posedge clk);
    timerSync <= t;
    pwmSync <= p;
    @(posedge clk);
    timerSync <= 1'b0;
    pwmSync <= 1'b0;
  endtask
  // expected outputs while cut off, active-high polarity so inactive is low
  function automatic logic [5:0] cut_model(input int m, input logic [5:0] p, input logic [5:0] w);
    int up;
    int lo;
    up = int'(p[0]) + int'(p[1]) + int'(p[2]);
    lo = int'(p[3]) + int'(p[4]) + int'(p[5]);
    case (m)
      0: return p;
      1: return 6'h00;
      2: return p & ~w;
      default: return (up >= 2) ? 6'h07 : ((lo >= 2) ? 6'h38 : 6'h00);
    endcase
  endfunction
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(14789));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    pattern <= 6'($urandom);
    wb(`MOP_ADR_EMG_CTRL, 1'b0, 8'h00);
    chk("emergency_control reset", 32'h01, rd);
    wb(`MOP_ADR_OVL_CTRL, 1'b0, 8'h00);
    chk("overload_control reset", 32'h00, rd);
    wb(`MOP_ADR_KEY, 1'b1, 8'h77);
    wb(`MOP_ADR_KEY, 1'b0, 8'h00);
    chk("key read", 32'h00, rd);
    wb(16'h7E00, 1'b1, 8'hFF);
    wb(16'h7E00, 1'b0, 8'h00);
    chk("unmapped read", 32'h00, rd);
    chk("outputs follow pattern", {26'h0, pattern}, {26'h0, motorOut});
    $display("test registers done");
    emgFault <= 1'b1;
    wait_irq(1'b0, 10, n);
    chk("emergency latency", 32'h1, 32'(n <= 6));
    chk("outputs hi-z", 32'h3F, {26'h0, motorOutEn_n});
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h03);
    wb(`MOP_ADR_EMG_CTRL, 1'b0, 8'h00);
    chk("status held while low", 32'h05, rd);
    chk("still hi-z", 32'h3F, {26'h0, motorOutEn_n});
    emgFault <= 1'b0;
    ctrl = {2'b00, pattern};
    // software clears the pattern before asking for the return
    pattern <= 6'h00;
    repeat (5) @(posedge clk);
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h03);
    repeat (2) @(posedge clk);
    chk("outputs driven again", 32'h00, {26'h0, motorOutEn_n});
    chk("cleared pattern out", 32'h00, {26'h0, motorOut});
    pattern <= ctrl[5:0];
    wb(`MOP_ADR_EMG_CTRL, 1'b0, 8'h00);
    chk("status cleared", 32'h01, rd);
    $display("test emergency done");
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h00);
    wb(`MOP_ADR_KEY, 1'b1, `MOP_KEY_SECOND);
    wb(`MOP_ADR_KEY, 1'b1, `MOP_KEY_FIRST);
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h00);
    wb(`MOP_ADR_EMG_CTRL, 1'b0, 8'h00);
    chk("locked disable", 32'h01, rd);
    wb(`MOP_ADR_KEY, 1'b1, `MOP_KEY_FIRST);
    wb(`MOP_ADR_KEY, 1'b1, `MOP_KEY_SECOND);
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h00);
    wb(`MOP_ADR_EMG_CTRL, 1'b0, 8'h00);
    chk("unlocked disable", 32'h00, rd);
    emgFault <= 1'b1;
    wait_irq(1'b0, 20, n);
    chk("no emergency irq", 32'd20, 32'(n));
    chk("no hi-z when off", 32'h00, {26'h0, motorOutEn_n});
    emgFault <= 1'b0;
    repeat (5) @(posedge clk);
    wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'h01);
    $display("test unlock done");
    for (int m = 0; m < 4; m++) begin
      cnt = (m == 2) ? 15 : m;
      eff = (cnt == 0) ? 1 : cnt;
      pattern <= 6'($urandom);
      pwmPhase <= 6'($urandom);
      ctrl = 8'(m << 2) | 8'h01 | 8'((m % 2) << 1) | rets[m];
      wb(`MOP_ADR_EMG_CTRL, 1'b1, 8'(cnt << 4) | 8'h01);
      wb(`MOP_ADR_OVL_CTRL, 1'b1, ctrl);
      ovlFault <= 1'b1;
      wait_irq(1'b1, 400, n);
      chk("detect time", 32'h1, 32'(n > (eff - 1) * 20 && n <= eff * 20 + 8));
      chk("cut outputs", {26'h0, cut_model(m, pattern, pwmPhase)}, {26'h0, motorOut});
      chk("counter halt", 32'(m % 2), {31'h0, counterHalt});
      pulse(1'b1, 1'b1);
      wb(`MOP_ADR_OVL_CTRL, 1'b0, 8'h00);
      chk("active while low", {24'h0, ctrl | 8'h10}, rd);
      ovlFault <= 1'b0;
      repeat (45) @(posedge clk);
      if (m == 1)
        pulse(1'b1, 1'b0);
      else if (m == 2)
        pulse(1'b0, 1'b1);
      else
        wb(`MOP_ADR_OVL_CTRL, 1'b1, ctrl | 8'h80);
      repeat (3) @(posedge clk);
      chk("pattern resumed", {26'h0, pattern}, {26'h0, motorOut});
      chk("halt released", 32'h0, {31'h0, counterHalt});
      wb(`MOP_ADR_OVL_CTRL, 1'b0, 8'h00);
      chk("overload status", {24'h0, ctrl}, rd);
      $display("test overload mode %0d done", m);
    end
    wb(`MOP_ADR_OVL_CTRL, 1'b1, 8'h04);
    ovlFault <= 1'b1;
    wait_irq(1'b1, 100, n);
    chk("no overload irq", 32'd100, 32'(n));
    chk("no cut when off", {26'h0, pattern}, {26'h0, motorOut});
    wb(`MOP_ADR_OVL_CTRL, 1'b0, 8'h00);
    chk("inactive status", 32'h04, rd);
    ovlFault <= 1'b0;
    $display("test overload disabled done");
    end_sim();
  end
endmodule
